// *** xpt_memory.sv ***
// Purpose: control memory latches for a 4 by 4 analog crosspoint array
// Assumes: host inputs are asynchronous pins; one strobe pulse per write
// Notes:   a write takes effect on the strobe's rising edge after sync
`timescale 1ns/100ps

// Summary of operation
// - sixteen latches, four rows of four, each alone sets its switch.
// - a strobe with data one turns the addressed switch on.
// - a strobe with data zero turns the addressed switch off.
// - with row clear, a strobe also turns off the rest of its row.
// - a strobe leaves all switches outside that set unchanged.
// - in both variants, reset turns every switch off.
module xpt_memory
  import xpt_pkg::*;
#(
  parameter bit ROW_CLEAR = 1'b1
)(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] sw_addr,
  input  wire logic              sw_data,
  input  wire logic              sw_strobe,
  output logic      [SW_N-1:0]   sw_on
);

  // the select logic and the checks below assume this exact geometry
  if ((ROW_LSB + ROW_W) != ADDR_W || ROWS_N != (1 << ROW_W) ||
      COLS_N != (1 << COL_W) || SW_N != 16) begin : g_bad_geometry
    $error("crosspoint geometry must be 4 by 4");
  end

  if (SYNC_DEPTH != 2) begin : g_bad_sync
    $error("the pin synchroniser is built two stages deep");
  end

  xpt_state_s state_reg;
  xpt_state_s state_next;
  logic            strobe_rise;
  logic [SW_N-1:0] hit_mask;
  logic [SW_N-1:0] row_mask;

  // one compare per latch: is it the addressed one, does it share the row
  for (genvar g = 0; g < SW_N; g++) begin : g_select
    localparam logic [ADDR_W-1:0] SLOT = ADDR_W'(g);
    assign hit_mask[g] = state_reg.sync.addr == SLOT;
    assign row_mask[g] = state_reg.sync.addr[ROW_LSB +: ROW_W]
                         == SLOT[ROW_LSB +: ROW_W];
  end

  always_comb begin
    state_next = state_reg;
    state_next.meta.addr   = sw_addr;
    state_next.meta.data   = sw_data;
    state_next.meta.strobe = sw_strobe;
    state_next.sync        = state_reg.meta;
    state_next.strobe_last = state_reg.sync.strobe;
    // address and data are sampled with the strobe; the host keeps them
    // stable around it, so the two-stage copy is coherent at the edge
    strobe_rise = state_reg.sync.strobe && !state_reg.strobe_last;
    if (strobe_rise) begin
      if (ROW_CLEAR) begin
        state_next.latch = state_reg.latch & ~row_mask;
      end
      state_next.latch = state_next.latch & ~hit_mask;
      if (state_reg.sync.data) begin
        state_next.latch = state_next.latch | hit_mask;
      end
      // latches outside both masks keep their value
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg <= '0;
      // without row clear the latches power up undefined in the part;
      // clearing them anyway keeps the switch state known
      state_reg.latch <= SW_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sw_on = state_reg.latch;

  // helper view of the write pipeline for the checks below; rise_d is
  // rebuilt here rather than taken from the latch logic it checks
  logic              rise_d;
  logic [ADDR_W-1:0] addr_d;
  logic              data_d;
  logic [ROW_W-1:0]  row_d;
  logic [COL_W-1:0]  col_d;
  assign rise_d = state_reg.sync.strobe && !state_reg.strobe_last;
  assign addr_d = state_reg.sync.addr;
  assign data_d = state_reg.sync.data;
  assign row_d  = addr_d[ROW_LSB +: ROW_W];
  assign col_d  = addr_d[COL_W-1:0];

  // a write as the latches see it, behind the pin synchroniser
  sequence s_write;
    rise_d;
  endsequence

  // a write as the host makes it: strobe pin sampled low, then high
  sequence s_pin_rise;
    !sw_strobe ##1 sw_strobe;
  endsequence

  // the host keeps the strobe up for at least one more sample
  sequence s_pin_hold;
    s_pin_rise ##1 sw_strobe;
  endsequence

  // a clearing write in the row-clear variant
  sequence s_row_wipe;
    s_write and !data_d and ROW_CLEAR;
  endsequence

  a_addressed_takes_data: assert property (@(posedge sys_clk)
    disable iff (!reset_n) s_write |=> sw_on[$past(addr_d)] == $past(data_d))
    else $error("addressed switch did not take data");

  a_row_companions_off: assert property (@(posedge sys_clk)
    disable iff (!reset_n) (s_write and ROW_CLEAR) |=>
      ((sw_on >> {$past(row_d), 2'h0}) & 16'h000f)
        == (16'h0001 << $past(col_d)) * $past(data_d))
    else $error("row companions not cleared");

  a_idle_holds: assert property (@(posedge sys_clk)
    disable iff (!reset_n) !rise_d |=> $stable(sw_on))
    else $error("switch changed without strobe");

  a_other_rows_hold: assert property (@(posedge sys_clk)
    disable iff (!reset_n) s_write |=>
      ((sw_on ^ $past(sw_on)) &
       ~(16'h000f << {$past(row_d), 2'h0})) == 16'h0000)
    else $error("switch outside row changed");

  a_reset_clears: assert property (@(posedge sys_clk)
    !reset_n |=> sw_on == 16'h0000)
    else $error("reset left a switch on");

  a_set_drives_on: assert property (@(posedge sys_clk)
    disable iff (!reset_n) (s_write and data_d) |=> sw_on != 16'h0000)
    else $error("set write left all switches off");

  a_clear_drives_off: assert property (@(posedge sys_clk)
    disable iff (!reset_n) (s_write and !data_d) |=> !sw_on[$past(addr_d)])
    else $error("clear write left switch on");

  a_one_write_per_pulse: assert property (@(posedge sys_clk)
    disable iff (!reset_n) s_write |=> !rise_d)
    else $error("strobe edge detected twice");

  // the pin edge needs two clocks through the synchroniser
  a_pin_reaches_edge: assert property (@(posedge sys_clk)
    disable iff (!reset_n) s_pin_rise |-> ##2 s_write)
    else $error("strobe pin rise gave no write");

  a_pin_sets_latch: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
      s_pin_rise |-> ##3 sw_on[$past(sw_addr, 3)] == $past(sw_data, 3))
    else $error("strobe pin write missed its latch");

  // a level-sensitive detector would write again on the held strobe
  a_held_strobe_once: assert property (@(posedge sys_clk)
    disable iff (!reset_n) s_pin_hold |-> ##2 !rise_d)
    else $error("held strobe wrote twice");

  // a reset inside the window can leave a high pin looking like an edge
  a_write_has_cause: assert property (@(posedge sys_clk)
    disable iff (!reset_n) s_write |->
      !$past(reset_n, 3) || ($past(sw_strobe, 2) && !$past(sw_strobe, 3)))
    else $error("write without a strobe pin rise");

  a_addr_two_late: assert property (@(posedge sys_clk)
    disable iff (!reset_n) $past(reset_n) && $past(reset_n, 2) |->
      addr_d == $past(sw_addr, 2) && data_d == $past(sw_data, 2))
    else $error("synchroniser lost the address");

  a_plain_single_bit: assert property (@(posedge sys_clk)
    disable iff (!reset_n) (s_write and !ROW_CLEAR) |=>
      ((sw_on ^ $past(sw_on)) & ~(16'h0001 << $past(addr_d))) == 16'h0000)
    else $error("plain write touched another switch");

  a_row_one_hot: assert property (@(posedge sys_clk)
    disable iff (!reset_n) (s_write and ROW_CLEAR) |=>
      $onehot0((sw_on >> {$past(row_d), 2'h0}) & 16'h000f))
    else $error("more than one switch on in a row");

  a_clear_row_dark: assert property (@(posedge sys_clk)
    disable iff (!reset_n) s_row_wipe |=>
      ((sw_on >> {$past(row_d), 2'h0}) & 16'h000f) == 16'h0000)
    else $error("cleared row still has a switch on");

  // no write can land before the synchroniser has refilled
  a_release_dark: assert property (@(posedge sys_clk)
    disable iff (!reset_n) $rose(reset_n) |-> ##2 sw_on == 16'h0000)
    else $error("switch on too soon after reset");
endmodule

// *** xpt_pkg.sv ***
// Purpose: shared constants and types for the crosspoint control memory
// Assumes: 4 by 4 switch array, one latch per switch
// Notes:   address is {row, column}, row in the upper two bits
package xpt_pkg;
  localparam int ROWS_N     = 4;
  localparam int COLS_N     = 4;
  localparam int ROW_W      = 2;
  localparam int COL_W      = 2;
  localparam int ADDR_W     = ROW_W + COL_W;
  localparam int SW_N       = ROWS_N * COLS_N;
  localparam int ROW_LSB    = COL_W;
  localparam int SYNC_DEPTH = 2;
  localparam logic [SW_N-1:0] SW_RESET = 16'h0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              data;
    logic              strobe;
  } host_req_s;

  typedef struct packed {
    host_req_s       meta;
    host_req_s       sync;
    logic            strobe_last;
    logic [SW_N-1:0] latch;
  } xpt_state_s;
endpackage

// *** host_model.sv ***
// Purpose: host that writes the crosspoint latches
// Assumes: pins change on the falling clock edge
// Notes:   released pins invert, so stale values never pass
`timescale 1ns/100ps
module host_model
  import xpt_pkg::*;
(
  input  wire logic              sys_clk,
  output logic      [ADDR_W-1:0] sw_addr,
  output logic                   sw_data,
  output logic                   sw_strobe
);
  initial {sw_addr, sw_data, sw_strobe} = '0;
  task automatic write(input logic [ADDR_W-1:0] a, input logic d);
    @(negedge sys_clk);
    {sw_addr, sw_data} = {a, d};
    repeat (2) @(negedge sys_clk);
    sw_strobe = 1'b1;
    repeat (5) @(negedge sys_clk);
    sw_strobe = 1'b0;
    repeat (2) @(negedge sys_clk);
    {sw_addr, sw_data} = ~{a, d};
  endtask
endmodule

// *** test_xpt_memory.sv ***
// Purpose: self-checking bench for the crosspoint memory
// Assumes: both variants, fed from one host
// Notes:   expected states queue up, a monitor compares them
`timescale 1ns/100ps
module test_xpt_memory
  import xpt_pkg::*;
;
  logic              sys_clk = 1'b0, reset_n = 1'b0, sw_data, sw_strobe;
  logic              wrote = 1'b0;
  logic [ADDR_W-1:0] sw_addr;
  logic [SW_N-1:0]   sw_on, model = SW_RESET, exp_q[$];
  logic [SW_N-1:0]   sw_keep, keep = SW_RESET, keep_q[$];
  int                num_errors = 0, total_checks = 0, seed = 32'h3e07938f;
  always #5 sys_clk = ~sys_clk;
  xpt_memory uut (.sys_clk(sys_clk), .reset_n(reset_n), .sw_addr(sw_addr),
    .sw_data(sw_data), .sw_strobe(sw_strobe), .sw_on(sw_on));
  // plain variant on the same pins: no row clear
  xpt_memory #(.ROW_CLEAR(1'b0)) uut_keep (.sys_clk(sys_clk),
    .reset_n(reset_n), .sw_addr(sw_addr), .sw_data(sw_data),
    .sw_strobe(sw_strobe), .sw_on(sw_keep));
  host_model host (.sys_clk(sys_clk), .sw_addr(sw_addr),
    .sw_data(sw_data), .sw_strobe(sw_strobe));
  task automatic check(input string n, input logic [SW_N-1:0] s, e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic put(input logic [ADDR_W-1:0] a, input logic d);
    model[int'(a[ADDR_W-1:ROW_LSB])*COLS_N +: COLS_N] = '0;
    model[a] = d;
    exp_q.push_back(model);
    keep[a] = d;
    keep_q.push_back(keep);
    host.write(a, d);
    wrote = 1'b1;
    @(negedge sys_clk) wrote = 1'b0;
  endtask
  task automatic do_reset;
    @(negedge sys_clk) reset_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    reset_n = 1'b1;
    model = SW_RESET;
    keep = SW_RESET;
    @(posedge sys_clk) #1 check("reset", sw_on, SW_RESET);
    check("reset_keep", sw_keep, SW_RESET);
  endtask
  initial begin
    do_reset();
    for (int i = 0; i < SW_N; i++) put(ADDR_W'(i), 1'b1);
    put(4'hf, 1'b0);
    $display("walk done");
    repeat (40) put(ADDR_W'($random(seed)), 1'($random(seed)));
    $display("random done");
    do_reset();
    put(4'h6, 1'b1);
    $display("reset done");
    repeat (2) @(posedge sys_clk);
    wrap_up();
  end
  always @(posedge sys_clk)
    if (wrote) begin
      check("sw_on", sw_on, exp_q.pop_front());
      check("sw_keep", sw_keep, keep_q.pop_front());
    end
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end
endmodule
